/* verilog/ahr_pkg.sv */
// constants for the converter host read port
package ahr_pkg;
  localparam int unsigned AHR_CLK_HZ = 10_000_000;
  localparam int unsigned AHR_CONV_TIME_NS = 2700;
  localparam int unsigned AHR_CLK_PERIOD_NS = 1_000_000_000 / AHR_CLK_HZ;
  localparam int unsigned AHR_CONV_CYCLES = AHR_CONV_TIME_NS / AHR_CLK_PERIOD_NS;
  localparam int unsigned AHR_RES_W = 12;
  localparam int unsigned AHR_NARROW_W = 8;
  localparam int unsigned AHR_NIBBLE_W = 4;
  localparam int unsigned AHR_CNT_W = 8;
  localparam logic [11:0] AHR_RESULT_RST = 12'h000;
  typedef enum logic [1:0] {
    AHR_IDLE = 2'b00,
    AHR_CONV = 2'b01,
    AHR_DONE = 2'b11
  } ahr_state_t;
endpackage

/* verilog/ahr_result_reg.sv */
// result holding register written at end of conversion
`timescale 1ns/1ps
`default_nettype none
module ahr_result_reg #(
  parameter int unsigned WIDTH = 12
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic wr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  output logic [WIDTH-1:0] rdata_out
);
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= '0;
    end else if (wr_in) begin
      rdata_out <= wdata_in;
    end
  end
endmodule
`default_nettype wire

/* verilog/ahr_read_port.sv */
// converter conversion control and result read port
`timescale 1ns/1ps
`default_nettype none
module ahr_read_port
  import ahr_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = ahr_pkg::AHR_CONV_CYCLES
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // host bus strobes
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic upper_byte_select_in,
  // conversion core
  input wire logic [ahr_pkg::AHR_RES_W-1:0] sample_in,
  // host data and status
  output logic busy_n_out,
  output logic [ahr_pkg::AHR_NIBBLE_W-1:0] upper_nibble_lines_out,
  output logic [ahr_pkg::AHR_NARROW_W-1:0] narrow_data_lines_out,
  output logic data_oe_out
);
  import ahr_pkg::*;

  ahr_state_t state_q;
  logic [AHR_CNT_W-1:0] cnt_q;
  logic [AHR_RES_W-1:0] result;
  logic rd_act;
  logic start;
  logic conv_end;
  logic [AHR_RES_W-1:0] out_src;
  logic [AHR_CNT_W-1:0] low_run_q;

  assign rd_act = !cs_n_in && !rd_n_in;
  assign start = rd_act && !upper_byte_select_in && (state_q == AHR_IDLE);
  assign conv_end = (state_q == AHR_CONV) && (cnt_q == AHR_CNT_W'(CONV_CYCLES - 1));
  // fresh sample bypasses the latch so data lands on the same edge busy rises
  assign out_src = conv_end ? sample_in : result;

  // conversion sequencer
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= AHR_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        AHR_IDLE: begin
          cnt_q <= '0;
          if (start) begin
            state_q <= AHR_CONV;
          end
        end
        AHR_CONV: begin
          cnt_q <= cnt_q + AHR_CNT_W'(1);
          if (conv_end) begin
            state_q <= AHR_DONE;
          end
        end
        AHR_DONE: begin
          // stay done until the starting read is released
          if (!rd_act) begin
            state_q <= AHR_IDLE;
          end
        end
        default: begin
          state_q <= AHR_IDLE;
        end
      endcase
    end
  end

  ahr_result_reg #(
    .WIDTH(AHR_RES_W)
  ) u_result (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .wr_in(conv_end),
    .wdata_in(sample_in),
    .rdata_out(result)
  );

  // busy and output drivers
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_n_out <= 1'b1;
    end else begin
      busy_n_out <= !(start || ((state_q == AHR_CONV) && !conv_end));
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      data_oe_out <= 1'b0;
      upper_nibble_lines_out <= '0;
      narrow_data_lines_out <= '0;
    end else begin
      data_oe_out <= rd_act;
      upper_nibble_lines_out <= out_src[11:8];
      if (upper_byte_select_in) begin
        narrow_data_lines_out <= {4'h0, out_src[11:8]};
      end else begin
        narrow_data_lines_out <= out_src[7:0];
      end
    end
  end

  // consecutive busy-low cycles, checked against the conversion length
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      low_run_q <= '0;
    end else if (!busy_n_out) begin
      low_run_q <= low_run_q + AHR_CNT_W'(1);
    end else begin
      low_run_q <= '0;
    end
  end

  sequence s_conv_begin;
    start ##1 (!busy_n_out && state_q == AHR_CONV);
  endsequence

  sequence s_conv_finish;
    conv_end ##1 (busy_n_out && state_q == AHR_DONE);
  endsequence

  sequence s_conv_run;
    !busy_n_out [*2];
  endsequence

  AST_BUSY_AFTER_START: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    start |=> !busy_n_out) else $error("busy not low after start");
  AST_BUSY_LENGTH: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    start |=> s_conv_run ##[0:100] busy_n_out) else $error("busy never released");
  AST_NO_START_HIGH_BYTE: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (rd_act && upper_byte_select_in && busy_n_out && state_q != AHR_CONV) |=> busy_n_out)
    else $error("high byte read started conversion");
  AST_NO_RESTART: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state_q == AHR_CONV && !conv_end) |=>
      (state_q == AHR_CONV) && (cnt_q == $past(cnt_q) + AHR_CNT_W'(1)))
    else $error("restart during conversion");
  AST_RESULT_ON_RELEASE: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    conv_end |=> (result == $past(sample_in)) && busy_n_out) else $error("result not loaded");
  AST_HIGH_BYTE_LAYOUT: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    upper_byte_select_in |=> narrow_data_lines_out == {4'h0, $past(out_src[11:8])})
    else $error("high byte layout wrong");
  AST_LOW_BYTE_LAYOUT: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (!upper_byte_select_in && !conv_end) |=> narrow_data_lines_out == $past(result[7:0]))
    else $error("low byte not previous result");
  AST_NIBBLE_ALWAYS: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    data_oe_out |-> upper_nibble_lines_out == $past(out_src[11:8]))
    else $error("msb nibble missing");
  AST_CONV_BEGIN: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    start |-> s_conv_begin) else $error("conversion did not begin");
  AST_CONV_FINISH: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    conv_end |-> s_conv_finish) else $error("conversion did not finish");
  AST_BUSY_RUN_LEN: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    $rose(busy_n_out) |-> (low_run_q == AHR_CNT_W'(CONV_CYCLES)))
    else $error("busy low length wrong");
  AST_NEW_LOW_AT_END: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (conv_end && !upper_byte_select_in) |=> narrow_data_lines_out == $past(sample_in[7:0]))
    else $error("new low byte late");
  AST_NEW_NIBBLE_AT_END: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    conv_end |=> upper_nibble_lines_out == $past(sample_in[11:8]))
    else $error("new msb nibble late");
  AST_RESULT_HELD: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !conv_end |=> $stable(result)) else $error("result changed mid conversion");
  AST_DONE_HOLDS: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state_q == AHR_DONE && rd_act) |=> (state_q == AHR_DONE))
    else $error("held read restarted conversion");
  AST_DONE_BUSY_HIGH: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state_q == AHR_DONE) |-> busy_n_out) else $error("busy low after conversion");
  AST_IDLE_BUSY_HIGH: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state_q == AHR_IDLE) |-> busy_n_out) else $error("busy low while idle");
  AST_OE_ON: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    rd_act |=> data_oe_out) else $error("drivers not enabled on read");
  AST_OE_OFF: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !rd_act |=> !data_oe_out) else $error("drivers enabled without read");
endmodule
`default_nettype wire

/* tb/ahr_host_model.sv */
// host bus model with wait glue and channel counter
`timescale 1ns/1ps
`default_nettype none
module ahr_host_model (
  // bus side
  input wire logic clk_sys_in,
  input wire logic busy_n_in,
  input wire logic [7:0] narrow_in,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic bsel_out
);
  logic transfer_ack_n;
  int chan = 0;
  assign transfer_ack_n = cs_n_out | ~busy_n_in;
  always @(posedge busy_n_in) chan <= chan + 1;
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    bsel_out = 1'b0;
  end
  task rd_cycle(input logic hi, input logic wt, output logic [7:0] d, output logic waited);
    int n;
    n = 0;
    waited = 1'b0;
    @(posedge clk_sys_in);
    cs_n_out <= 1'b0;
    rd_n_out <= 1'b0;
    bsel_out <= hi;
    repeat (2) @(posedge clk_sys_in);
    // acknowledge and data are taken at the same rising edge
    while (wt && transfer_ack_n !== 1'b0 && n < 100) begin
      waited = 1'b1;
      n++;
      @(posedge clk_sys_in);
    end
    d = narrow_in;
    cs_n_out <= 1'b1;
    rd_n_out <= 1'b1;
    // released select line shows the inverse of its last level
    bsel_out <= ~hi;
  endtask
endmodule
`default_nettype wire

/* tb/ahr_read_port_tb.sv */
// self-checking bench for the converter read port
`timescale 1ns/1ps
`default_nettype none
module ahr_read_port_tb;
  import ahr_pkg::*;
  localparam int unsigned CONV = 4;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cs_n, rd_n, bsel, busy_n, oe, w;
  logic [11:0] sample = 12'hA5C;
  logic [3:0] upper;
  logic [7:0] narrow, d;
  int fails = 0;
  int checks_done = 0;
  int c0;
  always #50 clk_sys_in = ~clk_sys_in;
  ahr_read_port #(.CONV_CYCLES(CONV)) u_ahr_read_port (.clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in), .cs_n_in(cs_n), .rd_n_in(rd_n), .upper_byte_select_in(bsel),
    .sample_in(sample), .busy_n_out(busy_n), .upper_nibble_lines_out(upper),
    .narrow_data_lines_out(narrow), .data_oe_out(oe));
  ahr_host_model u_ahr_host_model (.clk_sys_in(clk_sys_in), .busy_n_in(busy_n),
    .narrow_in(narrow), .cs_n_out(cs_n), .rd_n_out(rd_n), .bsel_out(bsel));
  task check(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task t_wait_low;
    u_ahr_host_model.rd_cycle(1'b0, 1'b1, d, w);
    check(d, 12'h05C);
    check(w, 12'h001);
    check(upper, 12'h00A);
  endtask
  task t_high;
    u_ahr_host_model.rd_cycle(1'b1, 1'b1, d, w);
    check(d, 12'h00A);
    check(w, 12'h000);
  endtask
  task t_pipe;
    @(posedge clk_sys_in);
    sample <= 12'h3C7;
    u_ahr_host_model.rd_cycle(1'b0, 1'b0, d, w);
    check(d, 12'h05C);
    repeat (CONV + 3) @(posedge clk_sys_in);
    u_ahr_host_model.rd_cycle(1'b0, 1'b0, d, w);
    check(d, 12'h0C7);
    repeat (CONV + 3) @(posedge clk_sys_in);
    check(12'(u_ahr_host_model.chan - c0), 12'h003);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    c0 = u_ahr_host_model.chan;
    t_wait_low;
    t_high;
    t_pipe;
    test_done;
  end
  initial begin
    #100000;
    fails++;
    test_done;
  end
endmodule
`default_nettype wire
